/* File: hdl/hpcp_defines.vh */
// Constants for the host port control pin block
`ifndef HPCP_DEFINES_VH
`define HPCP_DEFINES_VH
`define HPCP_SEL_CONTROL 2'h0
`define HPCP_SEL_DATA_INC 2'h1
`define HPCP_SEL_ADDRESS 2'h2
`define HPCP_SEL_DATA 2'h3
`define HPCP_ST_IDLE 2'h0
`define HPCP_ST_ACTIVE 2'h1
`define HPCP_ST_BUSY 2'h2
`define HPCP_ST_RELEASE 2'h3
`define HPCP_BUSY_CYCLES 4'h4
`define HPCP_SYNC_DEPTH 2
`endif

/* File: hdl/hpcp_sync.v */
// Two-flop synchroniser for a group of host inputs
module hpcp_sync #(
	parameter WIDTH = 1,
	parameter [0:0] INIT = 1'b0
) (
	input wire clk_i,
	input wire srst_i,
	input wire [WIDTH-1:0] d_i,
	output wire [WIDTH-1:0] q_o
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;
	always @(posedge clk_i) begin
		if (srst_i) begin
			meta_reg <= {WIDTH{INIT}};
			sync_reg <= {WIDTH{INIT}};
		end else begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
		end
	end
	assign q_o = sync_reg;
endmodule

/* File: hdl/hpcp_top.v */
// Host port control pins: pin function choice, access decode and ready
`include "hpcp_defines.vh"
module hpcp_top #(
	parameter BUSY_CYCLES = `HPCP_BUSY_CYCLES
) (
	input wire CLK_I,
	input wire SRST_I,
	input wire BOOT_SELECT_PIN_I,
	input wire PORT_ENABLE_INPUT_I,
	input wire SECOND_HOST_CONTROL_PIN_I,
	input wire ACCESS_SELECT_LOW_I,
	input wire ACCESS_SELECT_HIGH_I,
	input wire PORT_CHIP_SELECT_N_I,
	input wire READ_WRITE_SELECT_I,
	input wire DATA_STROBE_ONE_N_I,
	input wire DATA_STROBE_TWO_N_I,
	input wire ADDRESS_STROBE_INPUT_N_I,
	input wire XFER_DONE_I,
	output wire SECOND_HOST_CONTROL_PIN_O,
	output wire SECOND_HOST_CONTROL_PIN_OE_O,
	output wire ACCESS_SELECT_OE_O,
	output wire PORT_CHIP_SELECT_OE_O,
	output wire READ_WRITE_SELECT_OE_O,
	output wire PORT_READY_OUT_O,
	output wire PORT_READY_OUT_OE_O,
	output wire HOST_MODE_O,
	output wire PARALLEL_IO_BIT_FORTYFIVE_O,
	output wire XFER_REQ_O,
	output wire XFER_WRITE_O,
	output wire [1:0] XFER_SEL_O,
	output wire XFER_SECOND_BYTE_O,
	output wire ADDRESS_LATCH_O
);
	localparam [1:0] ST_IDLE = `HPCP_ST_IDLE;
	localparam [1:0] ST_ACTIVE = `HPCP_ST_ACTIVE;
	localparam [1:0] ST_BUSY = `HPCP_ST_BUSY;
	localparam [1:0] ST_RELEASE = `HPCP_ST_RELEASE;
	localparam [3:0] BUSY_LOAD = BUSY_CYCLES[3:0];
	wire s_as_n;
	wire s_bil;
	wire s_sel0;
	wire s_sel1;
	wire s_cs_n;
	wire s_rw;
	wire s_ds1_n;
	wire s_ds2_n;
	reg host_mode_reg;
	reg out_en_reg;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [3:0] cnt_reg;
	reg [3:0] cnt_next;
	reg req_reg;
	reg req_next;
	reg write_reg;
	reg write_next;
	reg [1:0] sel_reg;
	reg [1:0] sel_next;
	reg second_reg;
	reg second_next;
	reg ready_reg;
	reg ready_next;
	reg as_prev_reg;
	reg alatch_reg;
	reg pgpio_reg;
	wire strobe_active;
	wire selected;
	wire take;
	wire busy_over;
	wire release_ok;

	// Each synchroniser resets to its pin's idle level, so no false edge follows reset
	hpcp_sync #(.WIDTH(1), .INIT(1'b1)) u_cs_sync (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.d_i(PORT_CHIP_SELECT_N_I),
		.q_o(s_cs_n)
	);

	hpcp_sync #(.WIDTH(1), .INIT(1'b1)) u_as_sync (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.d_i(ADDRESS_STROBE_INPUT_N_I),
		.q_o(s_as_n)
	);

	hpcp_sync #(.WIDTH(1), .INIT(1'b0)) u_bil_sync (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.d_i(SECOND_HOST_CONTROL_PIN_I),
		.q_o(s_bil)
	);

	hpcp_sync #(.WIDTH(1), .INIT(1'b0)) u_sel0_sync (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.d_i(ACCESS_SELECT_LOW_I),
		.q_o(s_sel0)
	);

	hpcp_sync #(.WIDTH(1), .INIT(1'b0)) u_sel1_sync (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.d_i(ACCESS_SELECT_HIGH_I),
		.q_o(s_sel1)
	);

	hpcp_sync #(.WIDTH(1), .INIT(1'b1)) u_rw_sync (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.d_i(READ_WRITE_SELECT_I),
		.q_o(s_rw)
	);

	hpcp_sync #(.WIDTH(1), .INIT(1'b0)) u_ds1_sync (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.d_i(DATA_STROBE_ONE_N_I),
		.q_o(s_ds1_n)
	);

	hpcp_sync #(.WIDTH(1), .INIT(1'b1)) u_ds2_sync (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.d_i(DATA_STROBE_TWO_N_I),
		.q_o(s_ds2_n)
	);

	// Pin function caught on the last reset cycle, held afterwards
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			host_mode_reg <= BOOT_SELECT_PIN_I;
			out_en_reg <= 1'b0;
		end else begin
			out_en_reg <= 1'b1;
		end
	end

	// Strobe is the combination of both data strobes
	assign strobe_active = ~(s_ds1_n ^ s_ds2_n);
	assign selected = host_mode_reg & PORT_ENABLE_INPUT_I & ~s_cs_n & out_en_reg;

	// Transfer taken when an armed port sees an active strobe
	assign take = (state_reg == ST_ACTIVE) & selected & strobe_active;
	assign busy_over = XFER_DONE_I | (cnt_reg == 4'h0);
	assign release_ok = ~strobe_active | ~selected;

	// Port state sequence
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (selected && !strobe_active) begin
					state_next = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (!selected) begin
					state_next = ST_IDLE;
				end else if (take) begin
					state_next = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (busy_over) begin
					state_next = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				if (release_ok) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Busy counter
	always @* begin
		cnt_next = cnt_reg;
		if (take) begin
			cnt_next = BUSY_LOAD;
		end else if ((state_reg == ST_BUSY) && (cnt_reg != 4'h0)) begin
			cnt_next = cnt_reg - 4'h1;
		end
	end

	// Access details held until the next transfer
	always @* begin
		req_next = take;
		write_next = write_reg;
		sel_next = sel_reg;
		second_next = second_reg;
		if (take) begin
			write_next = ~s_rw;
			sel_next = {s_sel1, s_sel0};
			second_next = s_bil;
		end
	end

	// Ready drops on a taken transfer, returns after release
	always @* begin
		ready_next = ready_reg;
		if (take) begin
			ready_next = 1'b0;
		end else if ((state_reg == ST_RELEASE) && release_ok) begin
			ready_next = 1'b1;
		end
	end

	// State and counter registers
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// Transfer request and details
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			req_reg <= 1'b0;
			write_reg <= 1'b0;
			sel_reg <= `HPCP_SEL_CONTROL;
			second_reg <= 1'b0;
		end else begin
			req_reg <= req_next;
			write_reg <= write_next;
			sel_reg <= sel_next;
			second_reg <= second_next;
		end
	end

	// Ready register
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			ready_reg <= 1'b1;
		end else begin
			ready_reg <= ready_next;
		end
	end

	// Address strobe falling edge while selected
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			as_prev_reg <= 1'b1;
			alatch_reg <= 1'b0;
		end else begin
			as_prev_reg <= s_as_n;
			alatch_reg <= selected & as_prev_reg & ~s_as_n;
		end
	end

	// Parallel I/O bit follows its pin outside host mode
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			pgpio_reg <= 1'b0;
		end else begin
			pgpio_reg <= s_bil;
		end
	end

	// Control pins other than the ready pin are never driven by the port
	assign SECOND_HOST_CONTROL_PIN_O = 1'b0;
	assign SECOND_HOST_CONTROL_PIN_OE_O = 1'b0;
	assign ACCESS_SELECT_OE_O = 1'b0;
	assign PORT_CHIP_SELECT_OE_O = 1'b0;
	assign READ_WRITE_SELECT_OE_O = 1'b0;
	assign PORT_READY_OUT_O = ready_reg;
	assign PORT_READY_OUT_OE_O = out_en_reg & ~SRST_I & host_mode_reg & PORT_ENABLE_INPUT_I;
	assign HOST_MODE_O = host_mode_reg;
	assign PARALLEL_IO_BIT_FORTYFIVE_O = pgpio_reg & ~host_mode_reg;
	assign XFER_REQ_O = req_reg;
	assign XFER_WRITE_O = write_reg;
	assign XFER_SEL_O = sel_reg;
	assign XFER_SECOND_BYTE_O = second_reg;
	assign ADDRESS_LATCH_O = alatch_reg;
endmodule

/* File: test/hpcp_host_model.sv */
// Host bus master model for the host port
module hpcp_host_model (
	input wire logic clk_i,
	input wire logic rdy_i,
	output logic [7:0] pins_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic cs = 1;
	logic ds = 0;
	logic as_n = 1;
	logic [3:0] c = 0;
	assign pins_o = {cs, c[3], ds, 1'b1, as_n, c[2], c[1:0]};
	task automatic xfer(input logic s, input logic [3:0] v, input bit t, output bit bad);
		int n;
		@(posedge clk_i);
		{cs, c} <= {s, v};
		repeat (4) @(posedge clk_i);
		ds <= 1;
		n = 0;
		while (rdy_i && n++ < 12) @(posedge clk_i);
		bad = rdy_i !== !t;
		ds <= 0;
		n = 0;
		while (!rdy_i && n++ < 24) @(posedge clk_i);
		bad |= rdy_i !== 1'b1;
		cs <= 1;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic addr(input logic s);
		@(posedge clk_i);
		cs <= s;
		repeat (3) @(posedge clk_i);
		as_n <= 0;
		repeat (4) @(posedge clk_i);
		{cs, as_n} <= 2'h3;
		repeat (2) @(posedge clk_i);
	endtask
endmodule

/* File: test/hpcp_top_asserts.sv */
// Checker for the host port control pins
module hpcp_top_asserts (
	input wire CLK_I,
	input wire SRST_I,
	input wire BOOT_SELECT_PIN_I,
	input wire PORT_ENABLE_INPUT_I,
	input wire PORT_READY_OUT_O,
	input wire PORT_READY_OUT_OE_O,
	input wire HOST_MODE_O,
	input wire XFER_REQ_O,
	input wire ADDRESS_LATCH_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	sequence s_bz; !PORT_READY_OUT_O ##1 !XFER_REQ_O; endsequence
	property p_rz; disable iff (1'b0) SRST_I |-> !PORT_READY_OUT_OE_O; endproperty
	a_rz: assert property (p_rz) else $error("ready driven");
	property p_on; !$past(SRST_I) && HOST_MODE_O && PORT_ENABLE_INPUT_I |-> PORT_READY_OUT_OE_O; endproperty
	a_on: assert property (p_on) else $error("ready floats");
	property p_en; !PORT_ENABLE_INPUT_I |-> !PORT_READY_OUT_OE_O; endproperty
	a_en: assert property (p_en) else $error("port on");
	property p_ml; $fell(SRST_I) |-> HOST_MODE_O == $past(BOOT_SELECT_PIN_I); endproperty
	a_ml: assert property (p_ml) else $error("mode");
	property p_hd; !$past(SRST_I) |-> $stable(HOST_MODE_O); endproperty
	a_hd: assert property (p_hd) else $error("mode moved");
	property p_tk; XFER_REQ_O |-> s_bz; endproperty
	a_tk: assert property (p_tk) else $error("busy");
	property p_rq; XFER_REQ_O |-> $past(PORT_READY_OUT_O); endproperty
	a_rq: assert property (p_rq) else $error("not ready");
	property p_io; !HOST_MODE_O |-> !XFER_REQ_O && !PORT_READY_OUT_OE_O; endproperty
	a_io: assert property (p_io) else $error("io mode");
	property p_al; ADDRESS_LATCH_O |-> HOST_MODE_O && $past(PORT_ENABLE_INPUT_I); endproperty
	a_al: assert property (p_al) else $error("address latch");
endmodule

/* File: test/hpcp_top_tb.sv */
// Testbench for the host port control pins
module hpcp_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_I, SRST_I = 1, BOOT_SELECT_PIN_I = 0, PORT_ENABLE_INPUT_I = 1, XFER_DONE_I = 0;
	logic SECOND_HOST_CONTROL_PIN_I, ACCESS_SELECT_LOW_I, ACCESS_SELECT_HIGH_I, PORT_CHIP_SELECT_N_I;
	logic READ_WRITE_SELECT_I, DATA_STROBE_ONE_N_I, DATA_STROBE_TWO_N_I, ADDRESS_STROBE_INPUT_N_I;
	logic SECOND_HOST_CONTROL_PIN_O, SECOND_HOST_CONTROL_PIN_OE_O, ACCESS_SELECT_OE_O, PORT_CHIP_SELECT_OE_O;
	logic READ_WRITE_SELECT_OE_O, PORT_READY_OUT_O, PORT_READY_OUT_OE_O, HOST_MODE_O, PARALLEL_IO_BIT_FORTYFIVE_O;
	logic XFER_REQ_O, XFER_WRITE_O, XFER_SECOND_BYTE_O, ADDRESS_LATCH_O;
	logic [1:0] XFER_SEL_O;
	logic [3:0] q[$];
	int n_errors, check_count, n_latch;
	bit bad;
	hpcp_top DUT (.*);
	// Pull-up holds the ready pin high while it floats
	hpcp_host_model HOST (.clk_i(CLK_I), .rdy_i(PORT_READY_OUT_OE_O ? PORT_READY_OUT_O : 1'b1), .pins_o({PORT_CHIP_SELECT_N_I,
		READ_WRITE_SELECT_I, DATA_STROBE_ONE_N_I, DATA_STROBE_TWO_N_I, ADDRESS_STROBE_INPUT_N_I,
		SECOND_HOST_CONTROL_PIN_I, ACCESS_SELECT_HIGH_I, ACCESS_SELECT_LOW_I}));
	initial begin
		CLK_I = 0;
		forever #20 CLK_I = ~CLK_I;
	end
	task automatic chk(input logic [3:0] g, e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic rst(input logic b);
		{SRST_I, BOOT_SELECT_PIN_I} <= {1'b1, b};
		repeat (12) @(posedge CLK_I);
		{SRST_I, BOOT_SELECT_PIN_I} <= {1'b0, !b};
		repeat (2) @(posedge CLK_I);
	endtask
	task automatic go(input logic s, input logic [3:0] v, input bit t);
		if (t) q.push_back({!v[3], v[2:0]});
		HOST.xfer(s, v, t, bad);
		chk(bad, 0);
		if (bad) report_and_stop();
	endtask
	always @(posedge CLK_I) begin
		if (ADDRESS_LATCH_O === 1'b1) n_latch++;
		if (XFER_REQ_O === 1'b1) begin
			if (!q.size()) q.push_back(4'hx);
			chk({XFER_WRITE_O, XFER_SECOND_BYTE_O, XFER_SEL_O}, q.pop_front());
		end
	end
	initial begin
		void'($urandom(32'h21c4403f));
		rst(0);
		chk({SECOND_HOST_CONTROL_PIN_OE_O, ACCESS_SELECT_OE_O}, 0);
		chk({PORT_CHIP_SELECT_OE_O, READ_WRITE_SELECT_OE_O}, 0);
		go(0, 4'h4, 0);
		HOST.addr(0);
		chk(4'(n_latch), 0);
		chk({HOST_MODE_O, PARALLEL_IO_BIT_FORTYFIVE_O, PORT_READY_OUT_OE_O}, 2);
		rst(1);
		chk({HOST_MODE_O, PORT_READY_OUT_OE_O, PORT_READY_OUT_O, SECOND_HOST_CONTROL_PIN_OE_O}, 4'he);
		chk(SECOND_HOST_CONTROL_PIN_O, 0);
		HOST.addr(0);
		chk(4'(n_latch), 1);
		for (int i = 0; i < 8; i++) begin
			XFER_DONE_I <= 1'(i);
			go(0, {1'($urandom), 1'(i > 3), 2'(i)}, 1);
		end
		go(1, 4'h3, 0);
		PORT_ENABLE_INPUT_I <= 0;
		go(0, 4'h3, 0);
		chk(PORT_READY_OUT_OE_O, 0);
		PORT_ENABLE_INPUT_I <= 1;
		rst(1);
		go(0, 4'h9, 1);
		chk(4'(q.size()), 0);
		report_and_stop();
	end
endmodule
bind hpcp_top hpcp_top_asserts u_chk (.*);
